// file: rtl/tod_pkg.sv
// Constants and types of the master time-of-day engine
package tod_pkg;
	// ==========================================================
	// Clock and time spans
	localparam logic [31:0] CLK_HZ = 32'h01312D00;
	localparam logic [31:0] SECS_PER_WEEK = 32'h00093A80;
	localparam logic [31:0] SECS_PER_DAY = 32'h00015180;
	localparam logic [31:0] TAI_GPS_DAYS = 32'h00001F68;
	localparam logic [31:0] TAI_GPS_LEAP = 32'h00000013;
	localparam logic [39:0] EPOCH_SPAN = 40'(TAI_GPS_DAYS * SECS_PER_DAY + TAI_GPS_LEAP);
	localparam logic [11:0] NTSC_SECONDS = 12'h3E9;
	localparam logic [15:0] NTSC_FRAMES = 16'h7530;
	localparam logic [11:0] RES_STEP = 12'(NTSC_FRAMES % 16'(NTSC_SECONDS));
	localparam logic [16:0] DEFER_MAX_H = 17'h00018;
	localparam logic [16:0] DEFER_MAX_S = 17'(DEFER_MAX_H * 17'h00E10);
	// ==========================================================
	// Frame rates per output format
	localparam logic [35:0] RATE_25 = 36'h000000019;
	localparam logic [35:0] RATE_30 = 36'h00000001E;
	localparam logic [35:0] RATE_2997 = 36'h000007530;
	localparam logic [35:0] RATE_5994 = 36'h00000EA60;
	// ==========================================================
	// Reset values
	localparam logic [19:0] DST_RESET = 20'h00000;
	localparam logic [31:0] MASTER_RESET = 32'h00000000;
	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {REF_GPS = 2'h0, REF_GENLOCK = 2'h1, REF_INTERNAL = 2'h3} ref_t;
	typedef enum logic [1:0] {SRC_INTERNAL = 2'h0, SRC_GPS = 2'h1, SRC_VITC = 2'h3,
		SRC_LTC = 2'h2} src_t;
	typedef enum logic [1:0] {GL_NTSC = 2'h0, GL_PAL = 2'h1, GL_HD = 2'h3} genlock_std_t;
	typedef enum logic [1:0] {SYNC_NOW = 2'h0, SYNC_ONCE = 2'h1, SYNC_FOLLOW = 2'h3} sync_t;
	typedef enum logic [1:0] {DST_OFF = 2'h0, DST_ONCE = 2'h1, DST_RECUR = 2'h3} dst_mode_t;
	typedef enum logic [1:0] {FMT_25 = 2'h0, FMT_2997 = 2'h1, FMT_5994 = 2'h3,
		FMT_30 = 2'h2} fmt_t;
	typedef enum logic [1:0] {RES_LOAD = 2'h0, RES_RUN = 2'h1, RES_DONE = 2'h3} res_state_t;
endpackage

// file: rtl/master_time_of_day_engine.sv
// Master time-of-day engine: source select, corrections and frame pulses
`timescale 1ns/1ns
// Overview of operation
// - GPS time is weeks plus seconds since 1980
// - Reference limits which time sources are allowed
// - VITC only under NTSC/PAL genlock, no phasing
// - LTC input one allowed, never epoch phased
// - VITC sync: on command, once, or follow
// - Internal local set converted to GPS master
// - All timecode and phase from one master
// - Leap count stored, refreshed from satellite
// - SMPTE epoch is 8040 days plus 19s
// - Frame phase per second, NTSC 30000/1001
// - Frame pulses aligned to epoch phase
// - Per-output delay moves signal, not timecode
// - Stale leap flag until GPS count arrives
// - Signed zone offset in h, m, s
// - VITC source pre-corrected by zone offset
// - Zone change shifts timecode until resync
// - Leap minute extended with second 60
// - Once DST adds amount a single time
// - Recurring DST applied at begin, removed finish
// - UTC derived using GPS leap count
// - DST alters zone offset, master untouched
module master_time_of_day_engine #(
	parameter int N_OUT = 4,
	parameter logic [31:0] CYCLES_PER_SEC = tod_pkg::CLK_HZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Selection
	input wire logic [1:0] ref_sel,
	input wire logic [1:0] src_sel,
	input wire logic [1:0] genlock_std,
	input wire logic [1:0] sync_mode,
	input wire logic sync_cmd,
	// GPS receiver
	input wire logic gps_ok,
	input wire logic gps_pps,
	input wire logic gps_new,
	input wire logic [15:0] gps_week,
	input wire logic [31:0] gps_sow,
	input wire logic gps_leap_new,
	input wire logic [7:0] gps_leap,
	input wire logic leap_due,
	input wire logic [31:0] leap_epoch,
	input wire logic [7:0] stored_leap,
	// Reference decoders and internal set
	input wire logic vitc_ok,
	input wire logic vitc_new,
	input wire logic [31:0] vitc_time,
	input wire logic ltc_ok,
	input wire logic ltc_new,
	input wire logic [31:0] ltc_time,
	input wire logic time_set,
	input wire logic [31:0] set_time,
	// Zone, leap deferral and daylight saving
	input wire logic zone_neg,
	input wire logic [4:0] zone_hours,
	input wire logic [5:0] zone_minutes,
	input wire logic [5:0] zone_seconds,
	input wire logic defer_en,
	input wire logic [16:0] defer_secs,
	input wire logic [1:0] dst_mode,
	input wire logic dst_arm,
	input wire logic [19:0] dst_amount,
	input wire logic [31:0] dst_once_time,
	input wire logic [31:0] dst_begin_rule,
	input wire logic [31:0] dst_finish_rule,
	// Video outputs
	input wire logic [2*N_OUT-1:0] out_format,
	input wire logic [20*N_OUT-1:0] out_offset,
	output wire logic [N_OUT-1:0] frame_pulse,
	// Time and status
	output logic [31:0] master_time,
	output logic [31:0] utc_time,
	output logic [31:0] local_time,
	output logic [7:0] leap_count,
	output logic leap_second_now,
	output logic leap_info_stale,
	output logic source_lost,
	output logic [1:0] active_source,
	output logic epoch_active
);
	// ==========================================================
	// Second tick
	logic [31:0] sec_cnt;
	logic tick;
	assign tick = (sec_cnt == CYCLES_PER_SEC - 32'h1) ||
		(gps_pps && ref_sel == tod_pkg::REF_GPS);
	always_ff @(posedge clk) begin
		if (reset || tick) begin
			sec_cnt <= 32'h0;
		end else begin
			sec_cnt <= sec_cnt + 32'h1;
		end
	end
	// ==========================================================
	// Source selection
	tod_pkg::src_t eff_src;
	logic src_valid;
	always_comb begin
		eff_src = tod_pkg::SRC_INTERNAL;
		unique case (ref_sel)
			tod_pkg::REF_GPS: if (src_sel == tod_pkg::SRC_GPS) eff_src = tod_pkg::SRC_GPS;
			tod_pkg::REF_GENLOCK: begin
				if (src_sel == tod_pkg::SRC_VITC && genlock_std != tod_pkg::GL_HD) begin
					eff_src = tod_pkg::SRC_VITC;
				end else if (src_sel == tod_pkg::SRC_LTC) begin
					eff_src = tod_pkg::SRC_LTC;
				end
			end
			tod_pkg::REF_INTERNAL: if (src_sel == tod_pkg::SRC_LTC) eff_src = tod_pkg::SRC_LTC;
			default: eff_src = tod_pkg::SRC_INTERNAL;
		endcase
	end
	always_comb begin
		unique case (eff_src)
			tod_pkg::SRC_GPS: src_valid = gps_ok;
			tod_pkg::SRC_VITC: src_valid = vitc_ok;
			tod_pkg::SRC_LTC: src_valid = ltc_ok;
			default: src_valid = 1'b1;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			active_source <= tod_pkg::SRC_INTERNAL;
			epoch_active <= 1'b1;
			source_lost <= 1'b0;
		end else begin
			active_source <= eff_src;
			epoch_active <= eff_src == tod_pkg::SRC_GPS || eff_src == tod_pkg::SRC_INTERNAL;
			source_lost <= !src_valid;
		end
	end
	// ==========================================================
	// Zone offset with daylight saving
	logic [16:0] zone_mag;
	logic [19:0] zone_base;
	logic [19:0] dst_offset;
	logic [19:0] zone_eff;
	logic [31:0] zone32;
	assign zone_mag = 17'(zone_hours) * 17'h00E10 + 17'(zone_minutes) * 17'h0003C +
		17'(zone_seconds);
	assign zone_base = zone_neg ? 20'(-{3'h0, zone_mag}) : {3'h0, zone_mag};
	assign zone_eff = zone_base + dst_offset;
	assign zone32 = {{12{zone_eff[19]}}, zone_eff};
	// ==========================================================
	// Leap seconds
	logic [7:0] leap_local;
	logic [16:0] defer_cnt;
	logic [16:0] defer_limit;
	assign defer_limit = (defer_secs > tod_pkg::DEFER_MAX_S) ? tod_pkg::DEFER_MAX_S : defer_secs;
	always_ff @(posedge clk) begin
		if (reset) begin
			leap_count <= stored_leap;
			leap_info_stale <= 1'b1;
		end else if (gps_leap_new) begin
			leap_count <= gps_leap;
			leap_info_stale <= 1'b0;
		end else if (tick && leap_second_now) begin
			leap_count <= leap_count + 8'h01;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			leap_second_now <= 1'b0;
		end else if (tick) begin
			leap_second_now <= !leap_second_now && leap_due && master_time == leap_epoch;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			leap_local <= stored_leap;
			defer_cnt <= 17'h0;
		end else if (!defer_en) begin
			leap_local <= leap_count;
			defer_cnt <= 17'h0;
		end else if (tick && leap_local != leap_count) begin
			if (defer_cnt >= defer_limit) begin
				leap_local <= leap_count;
				defer_cnt <= 17'h0;
			end else begin
				defer_cnt <= defer_cnt + 17'h1;
			end
		end
	end
	// ==========================================================
	// Master time
	logic [31:0] gps_value;
	logic [31:0] local_in;
	logic [31:0] from_local;
	logic gps_load;
	logic local_load;
	logic vitc_load;
	logic once_done;
	assign gps_value = 32'(32'(gps_week) * tod_pkg::SECS_PER_WEEK) + gps_sow;
	assign gps_load = gps_new && gps_ok && eff_src == tod_pkg::SRC_GPS;
	always_comb begin
		unique case (sync_mode)
			tod_pkg::SYNC_NOW: vitc_load = sync_cmd;
			tod_pkg::SYNC_ONCE: vitc_load = vitc_new && !once_done;
			default: vitc_load = vitc_new;
		endcase
		vitc_load = vitc_load && vitc_ok && eff_src == tod_pkg::SRC_VITC;
	end
	assign local_load = vitc_load || (ltc_new && ltc_ok && eff_src == tod_pkg::SRC_LTC) ||
		(time_set && eff_src == tod_pkg::SRC_INTERNAL);
	assign local_in = (eff_src == tod_pkg::SRC_VITC) ? vitc_time :
		(eff_src == tod_pkg::SRC_LTC) ? ltc_time : set_time;
	assign from_local = local_in - zone32 + 32'(leap_local);
	always_ff @(posedge clk) begin
		if (reset) begin
			once_done <= 1'b0;
		end else if (vitc_load && sync_mode == tod_pkg::SYNC_ONCE) begin
			once_done <= 1'b1;
		end else if (sync_mode != tod_pkg::SYNC_ONCE || sync_cmd) begin
			once_done <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			master_time <= tod_pkg::MASTER_RESET;
		end else if (gps_load) begin
			master_time <= gps_value;
		end else if (local_load) begin
			master_time <= from_local;
		end else if (tick) begin
			master_time <= master_time + 32'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			utc_time <= 32'h0;
			local_time <= 32'h0;
		end else begin
			utc_time <= master_time - 32'(leap_count) - 32'(leap_second_now);
			local_time <= master_time - 32'(leap_local) -
				32'(leap_second_now && !defer_en) + zone32;
		end
	end
	// ==========================================================
	// Daylight saving scheduler
	logic dst_armed;
	logic [19:0] dst_mag;
	assign dst_mag = dst_amount[19] ? 20'(-dst_amount) : dst_amount;
	always_ff @(posedge clk) begin
		if (reset) begin
			dst_armed <= 1'b0;
		end else if (dst_arm) begin
			dst_armed <= 1'b1;
		end else if (tick && dst_mode == tod_pkg::DST_ONCE && local_time == dst_once_time) begin
			dst_armed <= 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset || dst_mode == tod_pkg::DST_OFF) begin
			dst_offset <= tod_pkg::DST_RESET;
		end else if (tick) begin
			if (dst_mode == tod_pkg::DST_ONCE) begin
				if (dst_armed && local_time == dst_once_time) begin
					dst_offset <= dst_offset + dst_amount;
				end
			end else if (local_time == dst_begin_rule) begin
				dst_offset <= dst_mag;
			end else if (local_time == dst_finish_rule) begin
				dst_offset <= tod_pkg::DST_RESET;
			end
		end
	end
	// ==========================================================
	// Epoch residue: next second's NTSC frame phase
	tod_pkg::res_state_t res_state;
	logic [39:0] res_shift;
	logic [11:0] res_acc;
	logic [5:0] res_bit;
	logic [11:0] residue;
	logic [11:0] residue2;
	function automatic logic [11:0] res_step(input logic [11:0] a, input logic b);
		logic [12:0] t;
		t = {a, 1'b0} + (b ? {1'b0, tod_pkg::RES_STEP} : 13'h0);
		if (t >= {tod_pkg::NTSC_SECONDS, 1'b0}) begin
			t = t - {tod_pkg::NTSC_SECONDS, 1'b0};
		end else if (t >= {1'b0, tod_pkg::NTSC_SECONDS}) begin
			t = t - {1'b0, tod_pkg::NTSC_SECONDS};
		end
		return t[11:0];
	endfunction
	always_ff @(posedge clk) begin
		if (reset) begin
			res_state <= tod_pkg::RES_LOAD;
			res_shift <= 40'h0;
			res_acc <= 12'h0;
			res_bit <= 6'h0;
			residue <= 12'h0;
		end else begin
			unique case (res_state)
				tod_pkg::RES_LOAD: begin
					res_shift <= {8'h0, master_time} + tod_pkg::EPOCH_SPAN + 40'h1;
					res_acc <= 12'h0;
					res_bit <= 6'h0;
					res_state <= tod_pkg::RES_RUN;
				end
				tod_pkg::RES_RUN: begin
					res_acc <= res_step(res_acc, res_shift[39]);
					res_shift <= {res_shift[38:0], 1'b0};
					res_bit <= res_bit + 6'h1;
					if (res_bit == 6'h27) res_state <= tod_pkg::RES_DONE;
				end
				tod_pkg::RES_DONE: begin
					residue <= res_acc;
					res_state <= tod_pkg::RES_LOAD;
				end
				default: res_state <= tod_pkg::RES_LOAD;
			endcase
		end
	end
	assign residue2 = res_step(residue, 1'b0) == residue ? residue :
		12'({1'b0, residue, 1'b0} >= {1'b0, tod_pkg::NTSC_SECONDS} ?
		{1'b0, residue, 1'b0} - {1'b0, tod_pkg::NTSC_SECONDS} : {1'b0, residue, 1'b0});
	// ==========================================================
	// Frame engines, one per video output
	for (genvar i = 0; i < N_OUT; i++) begin : g_out
		logic [35:0] acc;
		logic [35:0] step;
		logic [35:0] full;
		logic [35:0] init;
		logic [35:0] sum;
		logic [19:0] off;
		logic [19:0] dly;
		logic raw;
		logic pulse;
		logic frac;
		assign off = out_offset[20*i +: 20];
		always_comb begin
			unique case (out_format[2*i +: 2])
				tod_pkg::FMT_25: step = tod_pkg::RATE_25;
				tod_pkg::FMT_2997: step = tod_pkg::RATE_2997;
				tod_pkg::FMT_5994: step = tod_pkg::RATE_5994;
				default: step = tod_pkg::RATE_30;
			endcase
		end
		assign frac = out_format[2*i] == 1'b1;
		assign full = frac ? 36'(36'(tod_pkg::NTSC_SECONDS) * 36'(CYCLES_PER_SEC)) :
			36'(CYCLES_PER_SEC);
		assign init = !frac ? 36'h0 : 36'(36'(out_format[2*i+1] ? residue2 : residue) *
			36'(CYCLES_PER_SEC));
		assign sum = acc + step;
		always_ff @(posedge clk) begin
			if (reset) begin
				acc <= 36'h0;
				raw <= 1'b0;
			end else if (tick && epoch_active) begin
				acc <= init;
				raw <= init == 36'h0;
			end else if (sum >= full) begin
				acc <= sum - full;
				raw <= 1'b1;
			end else begin
				acc <= sum;
				raw <= 1'b0;
			end
		end
		always_ff @(posedge clk) begin
			if (reset) begin
				dly <= 20'h0;
				pulse <= 1'b0;
			end else if (raw) begin
				dly <= off;
				pulse <= off == 20'h0;
			end else if (dly != 20'h0) begin
				dly <= dly - 20'h1;
				pulse <= dly == 20'h1;
			end else begin
				pulse <= 1'b0;
			end
		end
		assign frame_pulse[i] = pulse;
	end
	// ==========================================================
	// Assertions
	a_gps_load_value: assert property (@(posedge clk) disable iff (reset)
		gps_load |=> master_time == $past(gps_value)) else $error("GPS load wrong");
	a_internal_only_src: assert property (@(posedge clk) disable iff (reset)
		ref_sel == tod_pkg::REF_INTERNAL |=> active_source != tod_pkg::SRC_GPS &&
		active_source != tod_pkg::SRC_VITC) else $error("Illegal source");
	a_vitc_genlock_only: assert property (@(posedge clk) disable iff (reset)
		active_source == tod_pkg::SRC_VITC |-> $past(ref_sel) == tod_pkg::REF_GENLOCK &&
		$past(genlock_std) != tod_pkg::GL_HD) else $error("VITC without SD genlock");
	a_epoch_off_tc: assert property (@(posedge clk) disable iff (reset)
		active_source == tod_pkg::SRC_VITC || active_source == tod_pkg::SRC_LTC |->
		!epoch_active) else $error("Epoch phasing on timecode source");
	a_master_counts: assert property (@(posedge clk) disable iff (reset)
		tick && !gps_load && !local_load |=> master_time == $past(master_time) + 32'h1)
		else $error("Master did not advance");
	a_stale_clear: assert property (@(posedge clk) disable iff (reset)
		gps_leap_new |=> !leap_info_stale && leap_count == $past(gps_leap))
		else $error("Leap info not refreshed");
	a_leap_second_start: assert property (@(posedge clk) disable iff (reset)
		$rose(leap_second_now) |-> $past(tick) && $past(leap_due) &&
		$past(master_time) == $past(leap_epoch)) else $error("Spurious leap second");
	a_dst_keep_master: assert property (@(posedge clk) disable iff (reset)
		dst_offset != $past(dst_offset) && !$past(gps_load) && !$past(local_load) &&
		$past(dst_mode) != tod_pkg::DST_OFF |-> master_time == $past(master_time) + 32'h1)
		else $error("DST moved master time");
endmodule // master_time_of_day_engine

// file: tb/tod_ref_source.sv
// Model of the GPS receiver and the VITC and LTC readers
`timescale 1ns/1ns
module tod_ref_source (
	// Clock
	input wire logic clk,
	// GPS receiver
	output logic gps_ok,
	output logic gps_pps,
	output logic gps_new,
	output logic [15:0] gps_week,
	output logic [31:0] gps_sow,
	output logic gps_leap_new,
	output logic [7:0] gps_leap,
	// Timecode readers
	output logic vitc_ok,
	output logic vitc_new,
	output logic [31:0] vitc_time,
	output logic ltc_ok,
	output logic ltc_new,
	output logic [31:0] ltc_time
);
	// ==========================================================
	// Idle lines
	initial begin
		{gps_ok, vitc_ok, ltc_ok} = 3'h7;
		{gps_pps, gps_new, gps_leap_new, vitc_new, ltc_new} = 5'h00;
		{gps_week, gps_sow, gps_leap} = 56'h5A5A5A5A5A5A5A;
		{vitc_time, ltc_time} = 64'hA5A5A5A55A5A5A5A;
	end
	// ==========================================================
	// Transfers, entered at a falling edge
	// Data inverted after each pulse so stale values never look valid
	task automatic pulse_pps;
		gps_pps = 1'b1;
		@(negedge clk);
		gps_pps = 1'b0;
	endtask
	task automatic set_gps_ok(input logic ok);
		gps_ok = ok;
	endtask
	task automatic set_tc_ok(input logic vitc, input logic ltc);
		{vitc_ok, ltc_ok} = {vitc, ltc};
	endtask
	task automatic send_gps(input logic [15:0] week, input logic [31:0] sow);
		{gps_week, gps_sow, gps_new} = {week, sow, 1'b1};
		@(negedge clk);
		{gps_week, gps_sow, gps_new} = {~week, ~sow, 1'b0};
	endtask
	task automatic send_leap(input logic [7:0] n);
		{gps_leap, gps_leap_new} = {n, 1'b1};
		@(negedge clk);
		{gps_leap, gps_leap_new} = {~n, 1'b0};
	endtask
	task automatic send_vitc(input logic [31:0] t);
		{vitc_time, vitc_new} = {t, 1'b1};
		@(negedge clk);
		{vitc_time, vitc_new} = {~t, 1'b0};
	endtask
	task automatic send_ltc(input logic [31:0] t);
		{ltc_time, ltc_new} = {t, 1'b1};
		@(negedge clk);
		{ltc_time, ltc_new} = {~t, 1'b0};
	endtask
endmodule // tod_ref_source

// file: tb/tb.sv
// Self-checking testbench of the master time-of-day engine
`timescale 1ns/1ns
module tb;
	// ==========================================================
	// Signals
	localparam logic [31:0] CPS = 32'h000000C8;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [1:0] ref_sel = 2'h3;
	logic [1:0] src_sel = 2'h0;
	logic [1:0] genlock_std = 2'h0;
	logic [1:0] sync_mode = 2'h3;
	logic sync_cmd = 1'b0;
	logic leap_due = 1'b0;
	logic [31:0] leap_epoch = 32'h00000000;
	logic time_set = 1'b0;
	logic [31:0] set_time = 32'h00000000;
	logic zone_neg = 1'b0;
	logic [4:0] zone_hours = 5'h01;
	logic [5:0] zone_minutes = 6'h1E;
	logic [5:0] zone_seconds = 6'h0F;
	logic [1:0] dst_mode = 2'h0;
	logic dst_arm = 1'b0;
	logic [19:0] dst_amount = 20'h00E10;
	logic [31:0] dst_once_time = 32'h00000000;
	logic [7:0] stored_leap = 8'h10;
	logic defer_en = 1'b0;
	logic [16:0] defer_secs = 17'h00000;
	logic [31:0] dst_begin_rule = 32'h00000000;
	logic [31:0] dst_finish_rule = 32'h00000000;
	logic [7:0] out_format = 8'hD0;
	logic [79:0] out_offset = 80'h00000000000000300000;
	wire logic gps_ok, gps_pps, gps_new, gps_leap_new, vitc_ok, vitc_new, ltc_ok, ltc_new;
	wire logic [15:0] gps_week;
	wire logic [31:0] gps_sow, vitc_time, ltc_time, master_time, utc_time, local_time;
	wire logic [7:0] gps_leap, leap_count;
	wire logic [3:0] frame_pulse;
	wire logic [1:0] active_source;
	wire logic leap_second_now, leap_info_stale, source_lost, epoch_active;
	int n_errors = 0;
	int cmp_count = 0;
	always #25 clk = ~clk;
	// ==========================================================
	// Engine and far side
	master_time_of_day_engine #(.N_OUT(4), .CYCLES_PER_SEC(CPS))
	u_master_time_of_day_engine (
		.clk, .reset, .ref_sel, .src_sel, .genlock_std, .sync_mode, .sync_cmd,
		.gps_ok, .gps_pps, .gps_new, .gps_week, .gps_sow, .gps_leap_new, .gps_leap,
		.leap_due, .leap_epoch, .stored_leap, .vitc_ok, .vitc_new, .vitc_time,
		.ltc_ok, .ltc_new, .ltc_time, .time_set, .set_time, .zone_neg, .zone_hours,
		.zone_minutes, .zone_seconds, .defer_en, .defer_secs, .dst_mode,
		.dst_arm, .dst_amount, .dst_once_time, .dst_begin_rule,
		.dst_finish_rule, .out_format, .out_offset, .frame_pulse,
		.master_time, .utc_time, .local_time, .leap_count, .leap_second_now,
		.leap_info_stale, .source_lost, .active_source, .epoch_active
	);
	tod_ref_source u_tod_ref_source (
		.clk, .gps_ok, .gps_pps, .gps_new, .gps_week, .gps_sow, .gps_leap_new, .gps_leap,
		.vitc_ok, .vitc_new, .vitc_time, .ltc_ok, .ltc_new, .ltc_time
	);
	// ==========================================================
	// Helpers
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic [31:0] zone_val();
		return 32'(zone_hours) * 32'h00000E10 + 32'(zone_minutes) * 32'h0000003C
			+ 32'(zone_seconds);
	endfunction
	task automatic wait_tick;
		logic [31:0] prev;
		prev = master_time;
		for (int k = 0; k < 400 && master_time === prev; k++) begin
			@(negedge clk);
		end
		cmp(32'(master_time !== prev), 32'h00000001);
	endtask
	task automatic close_out;
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_select;
		logic [8:0] tbl [11];
		// Reference, standard, request, granted source, phasing
		tbl = '{9'h00B, 9'h019, 9'h011, 9'h09E, 9'h0BE, 9'h0F9, 9'h089, 9'h0F4, 9'h194,
			9'h189, 9'h199};
		for (int i = 0; i < 11; i++) begin
			{ref_sel, genlock_std, src_sel} = tbl[i][8:3];
			step(2);
			cmp(32'(active_source), 32'(tbl[i][2:1]));
			cmp(32'(epoch_active), 32'(tbl[i][0]));
		end
	endtask
	task automatic t_gps_leap;
		logic [31:0] m;
		{ref_sel, src_sel} = 4'h1;
		u_tod_ref_source.pulse_pps();
		step(2);
		u_tod_ref_source.send_gps(16'h05E0, 32'h00049D40);
		step(1);
		cmp(master_time, 32'h000005E0 * tod_pkg::SECS_PER_WEEK + 32'h00049D40);
		u_tod_ref_source.send_leap(8'h12);
		step(2);
		cmp(32'(leap_count), 32'h00000012);
		cmp(32'(leap_info_stale), 32'h00000000);
		cmp(utc_time, master_time - 32'h00000012);
		u_tod_ref_source.set_gps_ok(1'b0);
		step(2);
		cmp(32'(source_lost), 32'h00000001);
		m = master_time;
		wait_tick();
		cmp(master_time, m + 32'h00000001);
		u_tod_ref_source.set_gps_ok(1'b1);
		m = master_time;
		leap_due = 1'b1;
		leap_epoch = m;
		wait_tick();
		leap_due = 1'b0;
		step(1);
		cmp(32'(leap_second_now), 32'h00000001);
		cmp(utc_time, m - 32'h00000012);
		wait_tick();
		step(2);
		cmp(32'(leap_count), 32'h00000013);
		cmp(32'(leap_second_now), 32'h00000000);
		cmp(utc_time, m - 32'h00000011);
	endtask
	task automatic t_internal_dst;
		logic [31:0] z;
		z = zone_val();
		{ref_sel, src_sel} = 4'hC;
		wait_tick();
		set_time = 32'h12345678;
		time_set = 1'b1;
		step(1);
		time_set = 1'b0;
		step(1);
		cmp(master_time, 32'h12345678 - z + 32'h00000013);
		step(1);
		cmp(local_time, 32'h12345678);
		zone_neg = 1'b1;
		step(3);
		cmp(local_time, 32'h12345678 - z - z);
		zone_neg = 1'b0;
		dst_mode = 2'h1;
		wait_tick();
		step(2);
		dst_once_time = local_time;
		dst_arm = 1'b1;
		step(1);
		dst_arm = 1'b0;
		repeat (2) begin
			wait_tick();
			step(2);
			cmp(local_time - master_time, z - 32'h00000013 + 32'h00000E10);
		end
		dst_mode = 2'h0;
	endtask
	task automatic t_vitc_ltc;
		logic [31:0] z;
		z = zone_val();
		{ref_sel, genlock_std, src_sel} = 6'h13;
		wait_tick();
		u_tod_ref_source.send_vitc(32'h00001000);
		step(2);
		cmp(local_time, 32'h00001000);
		u_tod_ref_source.set_tc_ok(1'b0, 1'b1);
		u_tod_ref_source.send_vitc(32'h00002000);
		u_tod_ref_source.set_tc_ok(1'b1, 1'b1);
		step(1);
		cmp(local_time, 32'h00001000);
		sync_mode = 2'h1;
		step(1);
		u_tod_ref_source.send_vitc(32'h00003000);
		step(2);
		cmp(local_time, 32'h00003000);
		u_tod_ref_source.send_vitc(32'h00004000);
		step(2);
		cmp(local_time, 32'h00003000);
		zone_neg = 1'b1;
		step(3);
		cmp(local_time, 32'h00003000 - z - z);
		sync_mode = 2'h0;
		step(1);
		sync_cmd = 1'b1;
		u_tod_ref_source.send_vitc(32'h00005000);
		sync_cmd = 1'b0;
		step(2);
		cmp(local_time, 32'h00005000);
		zone_neg = 1'b0;
		{ref_sel, src_sel} = 4'hE;
		wait_tick();
		u_tod_ref_source.send_ltc(32'h00006000);
		step(2);
		cmp(local_time, 32'h00006000);
		u_tod_ref_source.set_tc_ok(1'b1, 1'b0);
		u_tod_ref_source.send_ltc(32'h00007000);
		step(1);
		cmp(32'(source_lost), 32'h00000001);
		cmp(local_time, 32'h00006000);
		u_tod_ref_source.set_tc_ok(1'b1, 1'b1);
	endtask
	task automatic t_frames;
		int c [4];
		int mis;
		logic [2:0] d0;
		c = '{0, 0, 0, 0};
		mis = 0;
		d0 = 3'h0;
		{ref_sel, src_sel} = 4'hC;
		step(40);
		for (int k = 0; k < 2002; k++) begin
			@(negedge clk);
			if (k >= 2) begin
				for (int i = 0; i < 4; i++) c[i] += int'(frame_pulse[i]);
			end
			if (k >= 3 && frame_pulse[1] !== d0[2]) mis++;
			d0 = {d0[1:0], frame_pulse[0]};
		end
		cmp(32'(c[0]), 32'h000000FA);
		cmp(32'(c[1]), 32'h000000FA);
		cmp(32'(mis), 32'h00000000);
		cmp(32'(c[2] >= 32'h0000012A && c[2] <= 32'h0000012D), 32'h00000001);
		cmp(32'(c[3] >= 32'h00000256 && c[3] <= 32'h00000259), 32'h00000001);
	endtask
	task automatic t_defer_dst;
		stored_leap = 8'h21;
		zone_hours = 5'h02;
		zone_minutes = 6'h00;
		zone_seconds = 6'h00;
		reset = 1'b1;
		step(3);
		reset = 1'b0;
		cmp(master_time, 32'h00000000);
		cmp(32'(leap_count), 32'h00000021);
		cmp(32'(leap_info_stale), 32'h00000001);
		defer_en = 1'b1;
		defer_secs = 17'h00002;
		u_tod_ref_source.send_leap(8'h22);
		repeat (2) wait_tick();
		step(2);
		cmp(local_time - master_time, zone_val() - 32'h00000021);
		wait_tick();
		step(2);
		cmp(local_time - master_time, zone_val() - 32'h00000022);
		dst_amount = 20'hFF1F0;
		dst_mode = 2'h3;
		dst_begin_rule = local_time;
		wait_tick();
		step(2);
		cmp(local_time - master_time, zone_val() - 32'h00000022 + 32'h00000E10);
		dst_finish_rule = local_time;
		wait_tick();
		step(2);
		cmp(local_time - master_time, zone_val() - 32'h00000022);
		dst_mode = 2'h0;
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		step(10);
		reset = 1'b0;
		cmp(master_time, 32'h00000000);
		cmp(32'(leap_count), 32'h00000010);
		cmp(32'(leap_info_stale), 32'h00000001);
		cmp(32'(source_lost), 32'h00000000);
		t_select();
		t_gps_leap();
		t_internal_dst();
		t_vitc_ltc();
		t_frames();
		t_defer_dst();
		close_out();
	end
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		close_out();
	end
endmodule // tb
